// File: pkg/poic_pkg.sv
package poic_pkg;

   // Bus and datapath widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int BE_W   = 4;
   localparam int CODE_W = 16;
   localparam int PIX_W  = 12;
   localparam int IDX_W  = 6;

   // Register indices, byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_STATUS  = 6'h00;
   localparam logic [IDX_W-1:0] IDX_ABS     = 6'h01;
   localparam logic [IDX_W-1:0] IDX_ABS_MIN = 6'h05;
   localparam logic [IDX_W-1:0] IDX_ABS_MAX = 6'h09;
   localparam logic [IDX_W-1:0] IDX_CODE    = 6'h0D;
   localparam logic [IDX_W-1:0] IDX_FLOOR   = 6'h0F;
   localparam logic [IDX_W-1:0] IDX_CEIL    = 6'h11;
   localparam logic [IDX_W-1:0] IDX_MODE    = 6'h14;

   // Status field values
   localparam logic [7:0] STATUS_OFF = 8'h00;
   localparam logic [7:0] STATUS_OK  = 8'h01;

   // Output mode codes, the fourth code is illegal
   localparam logic [1:0] MODE_8  = 2'h0;
   localparam logic [1:0] MODE_10 = 2'h1;
   localparam logic [1:0] MODE_12 = 2'h2;
   localparam logic [1:0] MODE_BAD = 2'h3;

   // Code steps per digital number, as shift counts
   localparam logic [2:0] SHIFT_8  = 3'h4;
   localparam logic [2:0] SHIFT_10 = 3'h2;
   localparam logic [2:0] SHIFT_12 = 3'h0;

   // Permitted code range per mode, two's complement
   localparam logic [CODE_W-1:0] FLOOR_8  = 16'hF000;
   localparam logic [CODE_W-1:0] CEIL_8   = 16'h0FFF;
   localparam logic [CODE_W-1:0] FLOOR_10 = 16'hFC00;
   localparam logic [CODE_W-1:0] CEIL_10  = 16'h03FF;
   localparam logic [CODE_W-1:0] FLOOR_12 = 16'hFF00;
   localparam logic [CODE_W-1:0] CEIL_12  = 16'h00FF;

   // Largest pixel value per mode
   localparam logic [PIX_W-1:0] PIX_MAX_8  = 12'h0FF;
   localparam logic [PIX_W-1:0] PIX_MAX_10 = 12'h3FF;
   localparam logic [PIX_W-1:0] PIX_MAX_12 = 12'hFFF;

   // Single precision layout
   localparam logic [7:0]       EXP_BIAS  = 8'h7F;
   localparam logic [7:0]       EXP_SAT   = 8'h0B;
   localparam logic [7:0]       FRAC_TOP  = 8'h17;
   localparam logic [PIX_W-1:0] DN_SAT    = 12'h7FF;

   // Reset values
   localparam logic [1:0]        MODE_RESET = MODE_12;
   localparam logic [CODE_W-1:0] CODE_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] ABS_RESET  = 32'h00000000;
   localparam logic [DATA_W-1:0] RD_ZERO    = 32'h00000000;

   typedef struct packed {
      logic             valid;
      logic [PIX_W-1:0] data;
   } poic_pix_type;

   function automatic logic [2:0] poic_shift(input logic [1:0] mode);
      return (mode == MODE_8) ? SHIFT_8 : (mode == MODE_10) ? SHIFT_10 : SHIFT_12;
   endfunction : poic_shift

   function automatic logic [CODE_W-1:0] poic_floor(input logic [1:0] mode);
      return (mode == MODE_8) ? FLOOR_8 : (mode == MODE_10) ? FLOOR_10 : FLOOR_12;
   endfunction : poic_floor

   function automatic logic [CODE_W-1:0] poic_ceil(input logic [1:0] mode);
      return (mode == MODE_8) ? CEIL_8 : (mode == MODE_10) ? CEIL_10 : CEIL_12;
   endfunction : poic_ceil

   function automatic logic [PIX_W-1:0] poic_pix_max(input logic [1:0] mode);
      return (mode == MODE_8) ? PIX_MAX_8 : (mode == MODE_10) ? PIX_MAX_10 : PIX_MAX_12;
   endfunction : poic_pix_max

endpackage : poic_pkg

// File: rtl/poic_offset_scale.sv
module poic_offset_scale (
   input  wire logic                           clk,
   input  wire logic                           rst_n,
   input  wire logic [poic_pkg::CODE_W-1:0]    code,
   input  wire logic [1:0]                     mode,
   input  wire poic_pkg::poic_pix_type         pix_in,
   output poic_pkg::poic_pix_type              pix_out_q,
   output logic signed [poic_pkg::CODE_W-1:0]  dn_q
);
   import poic_pkg::*;

   // Arithmetic shift floors the code to whole digital numbers
   wire logic signed [CODE_W-1:0] dn_d     = $signed(code) >>> poic_shift(mode);
   wire logic signed [CODE_W+1:0] sum      = $signed({6'h00, pix_in.data})
                                             + $signed({{2{dn_d[CODE_W-1]}}, dn_d});
   wire logic        [PIX_W-1:0]  pix_max  = poic_pix_max(mode);
   wire logic                     sum_neg  = sum < 0;
   wire logic                     sum_high = sum > $signed({6'h00, pix_max});
   wire logic        [PIX_W-1:0]  pix_d    = sum_neg  ? '0 :
                                             sum_high ? pix_max : sum[PIX_W-1:0];

   // Offset applied to every pixel, clipped to the mode range
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pix_out_q <= '0;
         dn_q      <= '0;
      end else begin
         pix_out_q <= '{valid: pix_in.valid, data: pix_d};
         dn_q      <= dn_d;
      end
   end

   // Remainder of the code over one digital number step
   wire logic signed [CODE_W+4:0] rem = $signed({{5{code[CODE_W-1]}}, code})
                                      - $signed({{5{dn_d[CODE_W-1]}}, dn_d} << poic_shift(mode));

   a_dn_8bit: assert property (@(posedge clk) disable iff (!rst_n)
      (mode == MODE_8) |-> rem >= 0 && rem < 16) else $error("8 bit step wrong");
   a_dn_10bit: assert property (@(posedge clk) disable iff (!rst_n)
      (mode == MODE_10) |-> rem >= 0 && rem < 4) else $error("10 bit step wrong");
   a_dn_12bit: assert property (@(posedge clk) disable iff (!rst_n)
      (rst_n && mode == MODE_12) |=> dn_q == $past($signed(code)))
      else $error("12 bit step wrong");
   // Sampled reset keeps the release edge out: the flops still sit in reset there
   a_pix_offset: assert property (@(posedge clk) disable iff (!rst_n)
      (rst_n && pix_in.valid && !sum_neg && !sum_high) |=>
      pix_out_q.valid && $signed({6'h00, pix_out_q.data}) ==
      $past($signed({6'h00, pix_in.data})) + dn_q) else $error("pixel offset wrong");

endmodule : poic_offset_scale

// File: rtl/poic_top.sv
module poic_top (
   input  wire logic                           sys_clk,
   input  wire logic                           nrst,
   input  wire logic [poic_pkg::ADDR_W-1:0]    address,
   input  wire logic                           read,
   input  wire logic                           write,
   input  wire logic [poic_pkg::DATA_W-1:0]    writedata,
   input  wire logic [poic_pkg::BE_W-1:0]      byteenable,
   output logic      [poic_pkg::DATA_W-1:0]    readdata,
   output logic                                waitrequest,
   input  wire poic_pkg::poic_pix_type         pix_in,
   output poic_pkg::poic_pix_type              pix_out,
   output logic signed [poic_pkg::CODE_W-1:0]  offset_digital_number_unit
);
   import poic_pkg::*;

   // Reset release through two flops; assert stays asynchronous
   logic rst_meta_q;
   logic rst_n_q;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // Register state
   logic [CODE_W-1:0] code_q;
   logic [CODE_W-1:0] code_d;
   logic [DATA_W-1:0] abs_q;
   logic [DATA_W-1:0] abs_d;
   logic [1:0]        mode_q;
   logic [1:0]        mode_d;
   logic              wait_q;
   logic [DATA_W-1:0] rdata_q;

   // Turn an IEEE single into a code for the current mode
   function automatic logic [CODE_W-1:0] float_to_code(input logic [DATA_W-1:0] f,
                                                       input logic [1:0]        mode);
      logic [7:0]        e;
      logic [23:0]       m;
      logic [PIX_W-1:0]  mag;
      logic [CODE_W-1:0] v;
      e   = f[30:23];
      m   = {1'b1, f[22:0]};
      mag = '0;
      if (e >= EXP_BIAS + EXP_SAT) begin
         mag = DN_SAT;
      end else if (e >= EXP_BIAS) begin
         mag = PIX_W'(m >> (FRAC_TOP - (e - EXP_BIAS)));
      end
      v = {4'h0, mag} << poic_shift(mode);
      if (f[31]) begin
         v = CODE_W'(-v);
      end
      return v;
   endfunction : float_to_code

   // Clip a code into the permitted window of a mode
   function automatic logic [CODE_W-1:0] clamp_code(input logic [CODE_W-1:0] v,
                                                    input logic [1:0]        mode);
      logic [CODE_W-1:0] r;
      r = v;
      if ($signed(v) < $signed(poic_floor(mode))) begin
         r = poic_floor(mode);
      end else if ($signed(v) > $signed(poic_ceil(mode))) begin
         r = poic_ceil(mode);
      end
      return r;
   endfunction : clamp_code

   // Bus decode; the low two address bits are ignored
   wire logic [IDX_W-1:0] idx      = address[ADDR_W-1:2];
   wire logic             req      = read || write;
   wire logic             accept   = req && !wait_q;
   wire logic             wr_fire  = write && !wait_q;
   wire logic             hit_code = idx == IDX_CODE;
   wire logic             hit_abs  = idx == IDX_ABS;
   wire logic             hit_mode = idx == IDX_MODE;
   wire logic             wr_code  = wr_fire && hit_code;
   wire logic             wr_abs   = wr_fire && hit_abs;
   wire logic             wr_mode  = wr_fire && hit_mode && byteenable[0]
                                     && writedata[1:0] != MODE_BAD;

   // Byte lanes: lane 0 low byte, lane 1 high byte
   wire logic [CODE_W-1:0] code_merged = {byteenable[1] ? writedata[15:8] : code_q[15:8],
                                          byteenable[0] ? writedata[7:0]  : code_q[7:0]};

   wire logic [DATA_W-1:0] abs_merged;
   genvar gl;
   generate
      for (gl = 0; gl < BE_W; gl++) begin : g_abs_lane
         assign abs_merged[8*gl +: 8] = byteenable[gl] ? writedata[8*gl +: 8]
                                                       : abs_q[8*gl +: 8];
      end
   endgenerate

   // Limits track the mode register at all times
   wire logic [CODE_W-1:0] floor_now = poic_floor(mode_q);
   wire logic [CODE_W-1:0] ceil_now  = poic_ceil(mode_q);

   // Next code; clipped to the current mode_q, so after a mode change it is back inside one edge later
   wire logic [CODE_W-1:0] code_raw = wr_code ? code_merged
                                    : wr_abs  ? float_to_code(abs_merged, mode_q)
                                    : code_q;
   assign code_d = clamp_code(code_raw, mode_q);
   assign abs_d  = wr_abs ? abs_merged : abs_q;
   assign mode_d = wr_mode ? writedata[1:0] : mode_q;

   // Read mux; unmapped and float limit words read zero
   wire logic [DATA_W-1:0] rd_mux =
      (idx == IDX_STATUS) ? {24'h000000, STATUS_OK} :
      hit_abs             ? abs_q :
      hit_code            ? {16'h0000, code_q} :
      (idx == IDX_FLOOR)  ? {16'h0000, floor_now} :
      (idx == IDX_CEIL)   ? {16'h0000, ceil_now} :
      hit_mode            ? {30'h00000000, mode_q} :
                            RD_ZERO;

   // Control registers
   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         code_q <= CODE_RESET;
         abs_q  <= ABS_RESET;
         mode_q <= MODE_RESET;
      end else begin
         code_q <= code_d;
         abs_q  <= abs_d;
         mode_q <= mode_d;
      end
   end

   // One wait state: waitrequest drops for exactly one cycle per request
   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         wait_q  <= 1'b1;
         rdata_q <= RD_ZERO;
      end else begin
         wait_q  <= !(req && wait_q);
         rdata_q <= (read && wait_q) ? rd_mux : rdata_q;
      end
   end

   assign readdata    = rdata_q;
   assign waitrequest = wait_q;

   // Pixel path and applied offset
   poic_offset_scale u_scale (
      .clk       (sys_clk),
      .rst_n     (rst_n_q),
      .code      (code_q),
      .mode      (mode_q),
      .pix_in    (pix_in),
      .pix_out_q (pix_out),
      .dn_q      (offset_digital_number_unit)
   );

   // Checks
   sequence s_code_write_full;
      write && !wait_q && hit_code && byteenable[1:0] == 2'h3
      && $signed(writedata[15:0]) >= $signed(floor_now)
      && $signed(writedata[15:0]) <= $signed(ceil_now) && !wr_mode;
   endsequence

   sequence s_read_granted(logic [IDX_W-1:0] i);
      read && wait_q && idx == i ##1 !wait_q;
   endsequence

   a_code_write_sets: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      s_code_write_full |=> code_q == $past(writedata[15:0]))
      else $error("code write lost");

   a_code_low_byte: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      (wr_code && byteenable[1:0] == 2'h1 && $stable(mode_q)) |=>
      (code_q == clamp_code({$past(code_q[15:8]), $past(writedata[7:0])}, mode_q)))
      else $error("low byte lane wrong");

   a_floor_read: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      s_read_granted(IDX_FLOOR) |-> readdata == {16'h0000, poic_floor(mode_q)})
      else $error("floor read wrong");

   a_ceil_read: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      s_read_granted(IDX_CEIL) |-> readdata == {16'h0000, poic_ceil(mode_q)})
      else $error("ceiling read wrong");

   a_code_in_range: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      $stable(mode_q) |-> $signed(code_q) >= $signed(poic_floor(mode_q))
                       && $signed(code_q) <= $signed(poic_ceil(mode_q)))
      else $error("code outside limits");

   a_status_read: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      s_read_granted(IDX_STATUS) |-> readdata == {24'h000000, STATUS_OK})
      else $error("status read wrong");

   a_abs_write: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      (wr_abs && byteenable == 4'hF && !wr_mode) |=>
      abs_q == $past(writedata) && code_q == clamp_code(float_to_code(abs_q, mode_q), mode_q))
      else $error("float write not applied");

   a_wait_one: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      (req && wait_q) |=> !wait_q ##1 wait_q)
      else $error("waitrequest timing wrong");

   // Further steps of the register side
   sequence s_write_granted(logic [IDX_W-1:0] i);
      write && wait_q && idx == i ##1 !wait_q;
   endsequence

   sequence s_idle_cycle;
      !req && wait_q;
   endsequence

   sequence s_code_write_over;
      write && !wait_q && hit_code && byteenable[1:0] == 2'h3
      && $signed(writedata[15:0]) > $signed(ceil_now);
   endsequence

   sequence s_code_write_under;
      write && !wait_q && hit_code && byteenable[1:0] == 2'h3
      && $signed(writedata[15:0]) < $signed(floor_now);
   endsequence

   // Idle bus keeps waitrequest high; a finished access raises it again
   a_wait_idle: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      s_idle_cycle |=> wait_q)
      else $error("waitrequest dropped while idle");

   a_wait_release: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      accept |=> wait_q)
      else $error("waitrequest held low");

   // Read data stay put between reads, so a slow master still sees them
   a_rdata_hold: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      !(read && wait_q) |=> $stable(readdata))
      else $error("read data changed");

   // Mode register: legal codes land, the unused code is dropped
   a_mode_write: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      wr_mode |=> mode_q == $past(writedata[1:0]))
      else $error("mode write lost");

   a_mode_bad_kept: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      s_write_granted(IDX_MODE) ##0 writedata[1:0] == MODE_BAD |=> $stable(mode_q))
      else $error("illegal mode accepted");

   // High lane alone merges with the stored low byte
   a_code_high_byte: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      (wr_code && byteenable[1:0] == 2'h2) |=>
      (code_q == clamp_code({$past(writedata[15:8]), $past(code_q[7:0])}, mode_q)))
      else $error("high byte lane wrong");

   // Without a write the code only moves when the mode moves
   a_code_hold: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      (!wr_code && !wr_abs && $stable(mode_q)) |=> $stable(code_q))
      else $error("code changed without write");

   // Codes past either limit land on that limit, not refused
   a_code_clip_high: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      s_code_write_over |=> code_q == $past(ceil_now))
      else $error("code not clipped to ceiling");

   a_code_clip_low: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      s_code_write_under |=> code_q == $past(floor_now))
      else $error("code not clipped to floor");

   // A mode change pulls the code inside the new window on the next edge
   a_remode_clip: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      $changed(mode_q) |=> $signed(code_q) >= $signed(poic_floor(mode_q))
                        && $signed(code_q) <= $signed(poic_ceil(mode_q)))
      else $error("code not pulled into window");

   // Writes to read-only or unmapped words leave every field alone
   a_ro_write: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      (wr_fire && !hit_code && !hit_abs && !hit_mode && $stable(mode_q)) |=>
      $stable(code_q) && $stable(abs_q) && $stable(mode_q))
      else $error("read-only write took effect");

   // Read back; the value is the one stored when the read was taken
   a_code_read: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      s_read_granted(IDX_CODE) |-> readdata == {16'h0000, $past(code_q)})
      else $error("code read wrong");

   a_mode_read: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      s_read_granted(IDX_MODE) |-> readdata == {30'h00000000, $past(mode_q)})
      else $error("mode read wrong");

   a_abs_read: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      s_read_granted(IDX_ABS) |-> readdata == $past(abs_q))
      else $error("float read wrong");

   // Float limit words are not kept and read zero
   a_abs_min_read: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      s_read_granted(IDX_ABS_MIN) |-> readdata == RD_ZERO)
      else $error("float floor read wrong");

   a_abs_max_read: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
      s_read_granted(IDX_ABS_MAX) |-> readdata == RD_ZERO)
      else $error("float ceiling read wrong");

endmodule : poic_top

// File: test/poic_top_tb.sv
module poic_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import poic_pkg::*;

   // One table row: mode, code written, offset and pixel it should give
   typedef struct packed {
      logic [1:0]        mode;
      logic [CODE_W-1:0] code;
      logic [CODE_W-1:0] dn;
      logic [PIX_W-1:0]  pix;
   } poic_row_type;

   localparam logic [PIX_W-1:0] PIX_IN = 12'h080;
   localparam poic_row_type ROWS [7] = '{
      '{MODE_8,  16'h0010, 16'h0001, 12'h081},
      '{MODE_8,  16'h0FFF, 16'h00FF, 12'h0FF},
      '{MODE_8,  16'hFFF0, 16'hFFFF, 12'h07F},
      '{MODE_10, 16'h0004, 16'h0001, 12'h081},
      '{MODE_10, 16'hFC00, 16'hFF00, 12'h000},
      '{MODE_12, 16'h0001, 16'h0001, 12'h081},
      '{MODE_12, 16'hFFFF, 16'hFFFF, 12'h07F}};

   logic                     sys_clk = 1'b0;
   logic                     nrst = 1'b0;
   logic [ADDR_W-1:0]        address = 8'h00;
   logic                     read = 1'b0;
   logic                     write = 1'b0;
   logic [DATA_W-1:0]        writedata = 32'h00000000;
   logic [BE_W-1:0]          byteenable = 4'hF;
   logic [DATA_W-1:0]        readdata;
   logic                     waitrequest;
   poic_pix_type             pix_in = '0;
   poic_pix_type             pix_out;
   logic signed [CODE_W-1:0] offset_digital_number_unit;
   logic [DATA_W-1:0]        rd;
   int                       n_fail = 0;
   int                       comparisons = 0;

   poic_top uut (
      .sys_clk                    (sys_clk),
      .nrst                       (nrst),
      .address                    (address),
      .read                       (read),
      .write                      (write),
      .writedata                  (writedata),
      .byteenable                 (byteenable),
      .readdata                   (readdata),
      .waitrequest                (waitrequest),
      .pix_in                     (pix_in),
      .pix_out                    (pix_out),
      .offset_digital_number_unit (offset_digital_number_unit)
   );

   // Free running 10 MHz clock
   always #50 sys_clk = ~sys_clk;

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic end_sim;
      $display("checks %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim

   // One Avalon access; request held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd,
                      input logic [3:0] be, output logic [31:0] rdat);
      @(posedge sys_clk);
      address    <= {idx, 2'b00};
      read       <= ~wr;
      write      <= wr;
      writedata  <= wd;
      byteenable <= be;
      // Only the watchdog ends a wait that never completes
      do begin
         @(posedge sys_clk);
      end while (waitrequest !== 1'b0);
      rdat = readdata;
      read  <= 1'b0;
      write <= 1'b0;
   endtask : bus

   task automatic rd_chk(input string name, input logic [IDX_W-1:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h00000000, 4'hF, rd);
      check(name, rd, exp);
   endtask : rd_chk

   // Watchdog, the whole run needs well under 1000 cycles
   initial begin
      #200000;
      n_fail++;
      end_sim();
   end

   initial begin
      repeat (5) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      pix_in <= '{valid: 1'b1, data: PIX_IN};
      // Values after reset
      rd_chk("status", IDX_STATUS, {24'h000000, STATUS_OK});
      rd_chk("code_rst", IDX_CODE, 32'h00000000);
      rd_chk("floor_rst", IDX_FLOOR, {16'h0000, FLOOR_12});
      rd_chk("ceil_rst", IDX_CEIL, {16'h0000, CEIL_12});
      // Ordinary cases from the table
      foreach (ROWS[i]) begin
         bus(1'b1, IDX_MODE, {30'h0, ROWS[i].mode}, 4'hF, rd);
         rd_chk("floor", IDX_FLOOR,
                {16'h0000, ROWS[i].mode == MODE_8 ? FLOOR_8 :
                 ROWS[i].mode == MODE_10 ? FLOOR_10 : FLOOR_12});
         rd_chk("ceil", IDX_CEIL,
                {16'h0000, ROWS[i].mode == MODE_8 ? CEIL_8 :
                 ROWS[i].mode == MODE_10 ? CEIL_10 : CEIL_12});
         bus(1'b1, IDX_CODE, {16'h0000, ROWS[i].code}, 4'hF, rd);
         rd_chk("code", IDX_CODE, {16'h0000, ROWS[i].code});
         repeat (3) @(posedge sys_clk);
         check("offset", {16'h0000, offset_digital_number_unit},
               {16'h0000, ROWS[i].dn});
         check("pix", {19'h0, pix_out.valid, pix_out.data}, {19'h0, 1'b1, ROWS[i].pix});
      end
      // Byte lanes: low byte then high byte, mode is 12 bit here
      bus(1'b1, IDX_CODE, 32'h00000000, 4'hF, rd);
      bus(1'b1, IDX_CODE, 32'hAAAAAA34, 4'h1, rd);
      rd_chk("code_lo", IDX_CODE, 32'h00000034);
      bus(1'b1, IDX_CODE, 32'hAAAAFFAA, 4'h2, rd);
      rd_chk("code_hi", IDX_CODE, 32'h0000FF34);
      repeat (3) @(posedge sys_clk);
      check("offset_le", {16'h0000, offset_digital_number_unit}, 32'h0000FF34);
      // Out of range writes are clipped to the ceiling, then to the floor
      bus(1'b1, IDX_CODE, 32'h00007000, 4'hF, rd);
      rd_chk("code_clip", IDX_CODE, {16'h0000, CEIL_12});
      bus(1'b1, IDX_CODE, 32'h00008000, 4'hF, rd);
      rd_chk("code_clip_lo", IDX_CODE, {16'h0000, FLOOR_12});
      // Narrowing the mode pulls the code into the new range
      bus(1'b1, IDX_MODE, {30'h0, MODE_8}, 4'hF, rd);
      bus(1'b1, IDX_CODE, {16'h0000, FLOOR_8}, 4'hF, rd);
      bus(1'b1, IDX_MODE, {30'h0, MODE_12}, 4'hF, rd);
      rd_chk("code_remode", IDX_CODE, {16'h0000, FLOOR_12});
      // Illegal mode code is ignored
      bus(1'b1, IDX_MODE, {30'h0, MODE_BAD}, 4'hF, rd);
      rd_chk("ceil_bad", IDX_CEIL, {16'h0000, CEIL_12});
      rd_chk("mode_bad", IDX_MODE, {30'h0, MODE_12});
      // Read-only fields and unmapped space ignore writes
      bus(1'b1, IDX_FLOOR, 32'h00001234, 4'hF, rd);
      bus(1'b1, IDX_STATUS, 32'h00000000, 4'hF, rd);
      rd_chk("floor_ro", IDX_FLOOR, {16'h0000, FLOOR_12});
      rd_chk("status_ro", IDX_STATUS, {24'h000000, STATUS_OK});
      bus(1'b1, 6'h3F, 32'hFFFFFFFF, 4'hF, rd);
      rd_chk("unmapped", 6'h3F, RD_ZERO);
      // Float field: 5.0 in 12 bit mode gives code 5
      bus(1'b1, IDX_ABS, 32'h40A00000, 4'hF, rd);
      rd_chk("code_abs", IDX_CODE, 32'h00000005);
      rd_chk("abs_rd", IDX_ABS, 32'h40A00000);
      rd_chk("abs_min", IDX_ABS_MIN, RD_ZERO);
      rd_chk("abs_max", IDX_ABS_MAX, RD_ZERO);
      repeat (3) @(posedge sys_clk);
      check("offset_abs", {16'h0000, offset_digital_number_unit}, 32'h00000005);
      // Invalid input pixels must come out marked invalid
      pix_in <= '{valid: 1'b0, data: PIX_IN};
      repeat (2) @(posedge sys_clk);
      check("pix_idle", {31'h0, pix_out.valid}, 32'h00000000);
      // Second reset in mid-run clears the code
      @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check("wait_rst", {31'h0, waitrequest}, 32'h00000001);
      nrst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd_chk("code_rst2", IDX_CODE, 32'h00000000);
      end_sim();
   end

endmodule : poic_top_tb
